// ===== core/act_pkg.sv
package act_pkg;
  localparam int ACT_AW = 8;
  localparam int ACT_DW = 32;
  localparam int ACT_CNT_W = 16;
  localparam int ACT_DT_W = 8;
  localparam int ACT_SYNC_STAGES = 3;
  // register byte offsets
  localparam logic [7:0] ACT_OFF_CTRL = 8'h00;
  localparam logic [7:0] ACT_OFF_PSC = 8'h04;
  localparam logic [7:0] ACT_OFF_ARR = 8'h08;
  localparam logic [7:0] ACT_OFF_CNT = 8'h0C;
  localparam logic [7:0] ACT_OFF_CHMODE = 8'h10;
  localparam logic [7:0] ACT_OFF_DT = 8'h14;
  localparam logic [7:0] ACT_OFF_CCR0 = 8'h18;
  localparam logic [7:0] ACT_OFF_STAT = 8'h28;
  localparam logic [7:0] ACT_OFF_CLR = 8'h2C;
  localparam logic [7:0] ACT_OFF_IRQEN = 8'h30;
  localparam logic [7:0] ACT_OFF_DMAEN = 8'h34;
  // control fields
  localparam int ACT_CTRL_EN_BIT = 0;
  localparam int ACT_CTRL_MODE_LSB = 1;
  localparam int ACT_CTRL_OPM_BIT = 3;
  localparam int ACT_CTRL_FRZ_BIT = 4;
  localparam int ACT_CTRL_MOE_BIT = 5;
  localparam int ACT_CTRL_SLV_LSB = 6;
  localparam int ACT_CTRL_DIR_BIT = 8;
  localparam int ACT_CTRL_W = 8;
  localparam int ACT_CHMODE_POL_LSB = 8;
  localparam int ACT_STAT_UPD_BIT = 0;
  localparam int ACT_STAT_CC_LSB = 1;
  localparam int ACT_STAT_W = 5;
  // values after reset
  localparam logic [7:0] ACT_CTRL_RST = 8'h00;
  localparam logic [15:0] ACT_PSC_RST = 16'h0000;
  localparam logic [15:0] ACT_ARR_RST = 16'hFFFF;
  localparam logic [15:0] ACT_CHMODE_RST = 16'h0000;
  localparam logic [7:0] ACT_DT_RST = 8'h00;
  typedef enum logic [1:0] {ACT_CNT_UP, ACT_CNT_DOWN, ACT_CNT_CENTER} act_cnt_e;
  typedef enum logic [1:0] {ACT_SLV_OFF, ACT_SLV_TRIG, ACT_SLV_GATE, ACT_SLV_RESET} act_slv_e;
  typedef enum logic [1:0] {ACT_CH_CAPTURE, ACT_CH_TOGGLE, ACT_CH_PWM, ACT_CH_LOW} act_ch_e;
endpackage

// ===== core/act_channel.sv
`timescale 1ns/1ps
module act_channel
  import act_pkg::*;
#(
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // pin and configuration
  input wire logic pin_i,
  input wire act_pkg::act_ch_e mode_i,
  input wire logic cap_fall_i,
  // counter view
  input wire logic tick_i,
  input wire logic [CNT_W-1:0] cnt_i,
  // compare value write
  input wire logic wr_i,
  input wire logic [CNT_W-1:0] wdata_i,
  // results
  output logic [CNT_W-1:0] ccr_o,
  output logic ref_o,
  output logic event_o
);
  logic [ACT_SYNC_STAGES-1:0] sync_reg;
  logic level_reg;
  logic edge_hit;
  logic match;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      sync_reg <= '0;
      level_reg <= 1'b0;
    end else begin
      sync_reg <= {sync_reg[ACT_SYNC_STAGES-2:0], pin_i};
      // only the agreeing later stages may move the level
      if (sync_reg[1] == sync_reg[2]) begin
        level_reg <= sync_reg[2];
      end
    end
  end

  assign edge_hit = (sync_reg[1] == sync_reg[2]) && (sync_reg[2] != level_reg) &&
                    (sync_reg[2] != cap_fall_i);
  assign match = tick_i && (cnt_i == ccr_o);

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      ccr_o <= '0;
    end else if (mode_i == ACT_CH_CAPTURE && edge_hit) begin
      ccr_o <= cnt_i;
    end else if (wr_i) begin
      ccr_o <= wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      ref_o <= 1'b0;
      event_o <= 1'b0;
    end else begin
      unique case (mode_i)
        ACT_CH_CAPTURE: begin
          ref_o <= 1'b0;
          event_o <= edge_hit;
        end
        ACT_CH_TOGGLE: begin
          ref_o <= ref_o ^ match;
          event_o <= match;
        end
        ACT_CH_PWM: begin
          // zero gives 0 %, above the reload value gives 100 %
          ref_o <= (cnt_i < ccr_o);
          event_o <= match;
        end
        ACT_CH_LOW: begin
          ref_o <= 1'b0;
          event_o <= 1'b0;
        end
      endcase
    end
  end
endmodule

// ===== core/act_deadtime.sv
`timescale 1ns/1ps
module act_deadtime
  import act_pkg::*;
#(
  parameter int DT_W = 8
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // reference and setup
  input wire logic ref_i,
  input wire logic [DT_W-1:0] dt_i,
  input wire logic moe_i,
  // driver pair
  output logic pos_o,
  output logic neg_o
);
  logic prev_reg;
  logic [DT_W-1:0] gap_reg;
  logic settled;

  // both legs drop on any change, then only the new side may rise
  assign settled = (ref_i == prev_reg) && (gap_reg >= dt_i);

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      prev_reg <= 1'b0;
      gap_reg <= '0;
    end else if (ref_i != prev_reg) begin
      prev_reg <= ref_i;
      gap_reg <= '0;
    end else if (gap_reg < dt_i) begin
      gap_reg <= gap_reg + 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      pos_o <= 1'b0;
      neg_o <= 1'b0;
    end else begin
      pos_o <= moe_i && settled && prev_reg;
      neg_o <= moe_i && settled && !prev_reg;
    end
  end
endmodule

// ===== core/act_advanced_timer.sv
`timescale 1ns/1ps
// Functional notes
// - The 16-bit counter restarts by itself at the programmable reload value each period.
// - Counting runs up, down, or center-aligned up and down, chosen by configuration.
// - A 16-bit prescaler divides the counter clock by any integer from 1 to 65536.
// - Four independent channels each do capture, compare, PWM or one-pulse output.
// - PWM is edge-aligned or center-aligned depending on the counting arrangement.
// - Three complementary pairs get dead time so both legs are never active together.
// - Capture mode latches the counter on input edges to measure pulse lengths.
// - PWM duty spans the whole range from fully off to fully on.
// - The counter can be frozen while the processor is halted by a debugger.
// - Trigger signals let one timer start, gate or chain another.
// - Capture and compare events can request DMA transfers.
module act_advanced_timer
  import act_pkg::*;
#(
  parameter int N_CH = 4,
  parameter int N_CMP = 3
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // register port
  input wire logic [act_pkg::ACT_AW-1:0] reg_addr_i,
  input wire logic [act_pkg::ACT_DW-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [act_pkg::ACT_DW-1:0] reg_rdata_o,
  // capture pins
  input wire logic [N_CH-1:0] cap_i,
  // debug and timer link
  input wire logic dbg_halt_i,
  input wire logic trig_i,
  output logic trig_o,
  // driver outputs
  output logic [N_CH-1:0] ch_o,
  output logic [N_CMP-1:0] chn_o,
  // events
  output logic irq_o,
  output logic [N_CH:0] dma_req_o
);
  import act_pkg::*;

  if (N_CH != 4 || N_CMP != 3) begin : g_check
    $error("act_advanced_timer serves four channels and three pairs only");
  end

  logic [ACT_CTRL_W-1:0] ctrl_reg;
  logic [ACT_CNT_W-1:0] psc_reg;
  logic [ACT_CNT_W-1:0] arr_reg;
  logic [ACT_CNT_W-1:0] chmode_reg;
  logic [ACT_DT_W-1:0] dt_reg;
  logic [ACT_STAT_W-1:0] stat_reg;
  logic [ACT_STAT_W-1:0] irqen_reg;
  logic [ACT_STAT_W-1:0] dmaen_reg;
  logic [ACT_CNT_W-1:0] psc_cnt_reg;
  logic [ACT_CNT_W-1:0] cnt_reg;
  logic [ACT_CNT_W-1:0] cnt_next;
  logic dir_up_reg;
  logic dir_up_next;
  logic trig_prev_reg;
  logic trig_rise;
  logic running;
  logic tick;
  logic upd;
  logic slv_reset;
  act_cnt_e cnt_mode;
  act_slv_e slv_mode;
  logic [ACT_STAT_W-1:0] events;
  logic [N_CH-1:0] cc_event;
  logic [N_CH-1:0] ref_w;
  logic [N_CH-1:0] ccr_wr;
  logic [ACT_CNT_W-1:0] ccr_w [N_CH];
  logic wr_ctrl;
  logic wr_cnt;

  // offsets outside the map fall through every decode and are ignored
  assign cnt_mode = act_cnt_e'(ctrl_reg[ACT_CTRL_MODE_LSB +: 2]);
  assign slv_mode = act_slv_e'(ctrl_reg[ACT_CTRL_SLV_LSB +: 2]);
  assign wr_ctrl = reg_wr_i && (reg_addr_i == ACT_OFF_CTRL);
  assign wr_cnt = reg_wr_i && (reg_addr_i == ACT_OFF_CNT);

  // timer link input; the other timers share this clock
  assign trig_rise = trig_i && !trig_prev_reg;
  assign slv_reset = (slv_mode == ACT_SLV_RESET) && trig_rise;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      trig_prev_reg <= 1'b0;
    end else begin
      trig_prev_reg <= trig_i;
    end
  end

  // debug halt and gated slave mode both hold the prescaler too
  assign running = ctrl_reg[ACT_CTRL_EN_BIT] &&
                   !(ctrl_reg[ACT_CTRL_FRZ_BIT] && dbg_halt_i) &&
                   !((slv_mode == ACT_SLV_GATE) && !trig_i);
  // lowering PSC while the prescaler stands above it lets it run on to its wrap;
  // a CNT write clears the prescaler and restarts the division at once
  assign tick = running && (psc_cnt_reg == psc_reg);

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      psc_cnt_reg <= '0;
    end else if (wr_cnt || slv_reset || tick) begin
      psc_cnt_reg <= '0;
    end else if (running) begin
      psc_cnt_reg <= psc_cnt_reg + 1'b1;
    end
  end

  always_comb begin
    cnt_next = cnt_reg;
    dir_up_next = dir_up_reg;
    upd = 1'b0;
    if (tick) begin
      unique case (cnt_mode)
        ACT_CNT_DOWN: begin
          if (cnt_reg == '0 || cnt_reg > arr_reg) begin
            cnt_next = arr_reg;
            upd = 1'b1;
          end else begin
            cnt_next = cnt_reg - 1'b1;
          end
          dir_up_next = 1'b0;
        end
        ACT_CNT_CENTER: begin
          // turning points at both ends give the symmetric PWM
          if (dir_up_reg && cnt_reg >= arr_reg) begin
            cnt_next = (arr_reg == '0) ? '0 : arr_reg - 1'b1;
            dir_up_next = 1'b0;
            upd = 1'b1;
          end else if (!dir_up_reg && cnt_reg == '0) begin
            cnt_next = (arr_reg == '0) ? '0 : 16'h0001;
            dir_up_next = 1'b1;
            upd = 1'b1;
          end else if (dir_up_reg) begin
            cnt_next = cnt_reg + 1'b1;
          end else begin
            cnt_next = cnt_reg - 1'b1;
          end
        end
        default: begin
          if (cnt_reg >= arr_reg) begin
            cnt_next = '0;
            upd = 1'b1;
          end else begin
            cnt_next = cnt_reg + 1'b1;
          end
          dir_up_next = 1'b1;
        end
      endcase
    end
  end

  // a CNT write wins over a slave reset that lands in the same cycle
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      cnt_reg <= '0;
      dir_up_reg <= 1'b1;
    end else if (wr_cnt) begin
      cnt_reg <= reg_wdata_i[ACT_CNT_W-1:0];
    end else if (slv_reset) begin
      cnt_reg <= (cnt_mode == ACT_CNT_DOWN) ? arr_reg : '0;
      dir_up_reg <= (cnt_mode != ACT_CNT_DOWN);
    end else begin
      cnt_reg <= cnt_next;
      dir_up_reg <= dir_up_next;
    end
  end

  // control: trigger start sets the enable, one-pulse mode clears it
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      ctrl_reg <= ACT_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_reg <= reg_wdata_i[ACT_CTRL_W-1:0];
    end else if ((slv_mode == ACT_SLV_TRIG) && trig_rise) begin
      ctrl_reg[ACT_CTRL_EN_BIT] <= 1'b1;
    end else if (upd && ctrl_reg[ACT_CTRL_OPM_BIT]) begin
      ctrl_reg[ACT_CTRL_EN_BIT] <= 1'b0;
    end
  end

  // setup registers load at once, with no preload; a reload value below the
  // running count takes effect at the next tick because the up count uses >=
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      psc_reg <= ACT_PSC_RST;
    end else if (reg_wr_i && reg_addr_i == ACT_OFF_PSC) begin
      psc_reg <= reg_wdata_i[ACT_CNT_W-1:0];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      arr_reg <= ACT_ARR_RST;
    end else if (reg_wr_i && reg_addr_i == ACT_OFF_ARR) begin
      arr_reg <= reg_wdata_i[ACT_CNT_W-1:0];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      chmode_reg <= ACT_CHMODE_RST;
    end else if (reg_wr_i && reg_addr_i == ACT_OFF_CHMODE) begin
      chmode_reg <= reg_wdata_i[ACT_CNT_W-1:0];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      dt_reg <= ACT_DT_RST;
    end else if (reg_wr_i && reg_addr_i == ACT_OFF_DT) begin
      dt_reg <= reg_wdata_i[ACT_DT_W-1:0];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      irqen_reg <= '0;
    end else if (reg_wr_i && reg_addr_i == ACT_OFF_IRQEN) begin
      irqen_reg <= reg_wdata_i[ACT_STAT_W-1:0];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      dmaen_reg <= '0;
    end else if (reg_wr_i && reg_addr_i == ACT_OFF_DMAEN) begin
      dmaen_reg <= reg_wdata_i[ACT_STAT_W-1:0];
    end
  end

  // four channels share the counter; pairs get dead time
  for (genvar i = 0; i < N_CH; i++) begin : g_ch
    assign ccr_wr[i] = reg_wr_i &&
                       (reg_addr_i == ACT_OFF_CCR0 + 8'(4 * i));
    act_channel #(
      .CNT_W(ACT_CNT_W)
    ) u_channel (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .pin_i(cap_i[i]),
      .mode_i(act_ch_e'(chmode_reg[2*i +: 2])),
      .cap_fall_i(chmode_reg[ACT_CHMODE_POL_LSB + i]),
      .tick_i(tick),
      .cnt_i(cnt_reg),
      .wr_i(ccr_wr[i]),
      .wdata_i(reg_wdata_i[ACT_CNT_W-1:0]),
      .ccr_o(ccr_w[i]),
      .ref_o(ref_w[i]),
      .event_o(cc_event[i])
    );
    if (i < N_CMP) begin : g_pair
      act_deadtime #(
        .DT_W(ACT_DT_W)
      ) u_deadtime (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .ref_i(ref_w[i]),
        .dt_i(dt_reg),
        .moe_i(ctrl_reg[ACT_CTRL_MOE_BIT]),
        .pos_o(ch_o[i]),
        .neg_o(chn_o[i])
      );
    end else begin : g_single
      // the unpaired channel has no dead time to wait for
      logic solo_reg;

      always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
          solo_reg <= 1'b0;
        end else begin
          solo_reg <= ref_w[i] && ctrl_reg[ACT_CTRL_MOE_BIT];
        end
      end

      assign ch_o[i] = solo_reg;
    end
  end

  // bit 0 is the update flag, bits 1 to 4 the channel events
  assign events = {cc_event, upd};

  // sticky flags: a new event wins over a clear in the same cycle
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      stat_reg <= '0;
    end else if (reg_wr_i && reg_addr_i == ACT_OFF_CLR) begin
      stat_reg <= (stat_reg & ~reg_wdata_i[ACT_STAT_W-1:0]) | events;
    end else begin
      stat_reg <= stat_reg | events;
    end
  end

  // level output; it falls in the cycle after software clears the flag
  assign irq_o = |(stat_reg & irqen_reg);

  // requests are one-cycle pulses; the DMA side must take them as they stand
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      dma_req_o <= '0;
    end else begin
      dma_req_o <= events & dmaen_reg;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      trig_o <= 1'b0;
    end else begin
      trig_o <= upd;
    end
  end

  // read data stand for exactly one cycle after the strobe
  // CLR is write-only and reads zero like any offset outside the map
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= '0;
    end else if (!reg_rd_i) begin
      reg_rdata_o <= '0;
    end else begin
      unique case (reg_addr_i)
        ACT_OFF_CTRL: reg_rdata_o <= ACT_DW'({dir_up_reg, ctrl_reg});
        ACT_OFF_PSC: reg_rdata_o <= ACT_DW'(psc_reg);
        ACT_OFF_ARR: reg_rdata_o <= ACT_DW'(arr_reg);
        ACT_OFF_CNT: reg_rdata_o <= ACT_DW'(cnt_reg);
        ACT_OFF_CHMODE: reg_rdata_o <= ACT_DW'(chmode_reg);
        ACT_OFF_DT: reg_rdata_o <= ACT_DW'(dt_reg);
        ACT_OFF_CCR0: reg_rdata_o <= ACT_DW'(ccr_w[0]);
        ACT_OFF_CCR0 + 8'h04: reg_rdata_o <= ACT_DW'(ccr_w[1]);
        ACT_OFF_CCR0 + 8'h08: reg_rdata_o <= ACT_DW'(ccr_w[2]);
        ACT_OFF_CCR0 + 8'h0C: reg_rdata_o <= ACT_DW'(ccr_w[3]);
        ACT_OFF_STAT: reg_rdata_o <= ACT_DW'(stat_reg);
        ACT_OFF_IRQEN: reg_rdata_o <= ACT_DW'(irqen_reg);
        ACT_OFF_DMAEN: reg_rdata_o <= ACT_DW'(dmaen_reg);
        default: reg_rdata_o <= '0;
      endcase
    end
  end
endmodule

// ===== verif/act_advanced_timer_sva.sv
`timescale 1ns/1ps
module act_advanced_timer_chk
  import act_pkg::*;
#(
  parameter int N_CH = 4,
  parameter int N_CMP = 3
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // register port
  input wire logic [act_pkg::ACT_AW-1:0] reg_addr_i,
  input wire logic [act_pkg::ACT_DW-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [act_pkg::ACT_DW-1:0] reg_rdata_o,
  // outputs
  input wire logic trig_o,
  input wire logic [N_CH-1:0] ch_o,
  input wire logic [N_CMP-1:0] chn_o,
  input wire logic irq_o,
  input wire logic [N_CH:0] dma_req_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence rd_at(logic [7:0] a);
    reg_rd_i && reg_addr_i == a;
  endsequence
  sequence mask_off;
    reg_wr_i && reg_addr_i == ACT_OFF_IRQEN && reg_wdata_i[4:0] == 5'h00;
  endsequence
  pair_apart_a: assert property ((ch_o[N_CMP-1:0] & chn_o) == '0)
    else $error("both legs of a pair on");
  pos_gap_a: assert property (
    (ch_o[N_CMP-1:0] & ~$past(ch_o[N_CMP-1:0]) & $past(chn_o)) == '0)
    else $error("primary leg rose with no dead gap");
  neg_gap_a: assert property (
    (chn_o & ~$past(chn_o) & $past(ch_o[N_CMP-1:0])) == '0)
    else $error("complementary leg rose with no dead gap");
  rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == '0)
    else $error("read data outside its cycle");
  clr_zero_a: assert property (rd_at(ACT_OFF_CLR) |=> reg_rdata_o == '0)
    else $error("clear register read not zero");
  unmapped_a: assert property (rd_at(8'h38) or rd_at(8'hFC) |=> reg_rdata_o == '0)
    else $error("unmapped read not zero");
  half_word_a: assert property (
    rd_at(ACT_OFF_CNT) or rd_at(ACT_OFF_ARR) or rd_at(ACT_OFF_PSC)
    |=> reg_rdata_o[31:16] == 16'h0000)
    else $error("counter register wider than 16 bits");
  irq_mask_a: assert property (mask_off |=> !irq_o)
    else $error("interrupt with all enables off");
  dma_upd_a: assert property (dma_req_o[0] |-> trig_o)
    else $error("update request without update pulse");
endmodule
bind act_advanced_timer act_advanced_timer_chk #(.N_CH(N_CH), .N_CMP(N_CMP)) chk_inst (
  .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .trig_o(trig_o), .ch_o(ch_o), .chn_o(chn_o),
  .irq_o(irq_o), .dma_req_o(dma_req_o));

// ===== verif/act_stage_model.sv
`timescale 1ns/1ps
module act_stage_model (
  // clock
  input wire logic sys_clk_i,
  // pulse request
  input wire logic go_i,
  input wire logic [1:0] sel_i,
  input wire logic [7:0] len_i,
  // power stage legs
  input wire logic [3:0] drv_i,
  input wire logic [2:0] drvn_i,
  // sensor lines and fault count
  output logic [3:0] cap_o,
  output int shoot_o
);
  logic [7:0] left_reg = 8'h00;
  logic [1:0] sel_reg = 2'h0;
  always_ff @(posedge sys_clk_i) begin
    if (go_i) begin
      left_reg <= len_i;
      sel_reg <= sel_i;
    end else if (left_reg != 8'h00) begin
      left_reg <= left_reg - 8'h01;
    end
  end
  // sensor lines idle low; pulse width is exact in clock cycles
  assign cap_o = (left_reg != 8'h00) ? (4'h1 << sel_reg) : 4'h0;
  // both legs on would short the supply through the bridge
  always_ff @(posedge sys_clk_i) begin
    if ((drv_i[2:0] & drvn_i) != 3'h0) begin
      shoot_o <= shoot_o + 1;
    end
  end
endmodule

// ===== verif/test_advanced_control_timer.sv
`timescale 1ns/1ps
module test_advanced_control_timer;
  import act_pkg::*;
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [31:0] reg_rdata_o;
  logic [3:0] cap_i;
  logic dbg_halt_i = 1'b0;
  logic trig_i = 1'b0;
  logic trig_o;
  logic irq_o;
  logic [3:0] ch_o;
  logic [2:0] chn_o;
  logic [4:0] dma_req_o;
  logic go = 1'b0;
  logic [31:0] a;
  logic [31:0] b;
  int shoot;
  int n;
  int m;
  int dma_seen = 0;
  int num_errors = 0;
  int check_count = 0;
  int modes[4] = '{1, 3, 5, 1};
  int pers[4] = '{15, 15, 10, 3};
  int duty[3] = '{0, 5, 10};
  act_advanced_timer act_advanced_timer_inst (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .cap_i(cap_i), .dbg_halt_i(dbg_halt_i),
    .trig_i(trig_i), .trig_o(trig_o), .ch_o(ch_o), .chn_o(chn_o), .irq_o(irq_o),
    .dma_req_o(dma_req_o));
  act_stage_model act_stage_model_inst (.sys_clk_i(sys_clk_i), .go_i(go), .sel_i(2'h1),
    .len_i(8'd40), .drv_i(ch_o), .drvn_i(chn_o), .cap_o(cap_i), .shoot_o(shoot));
  initial begin
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    if (dma_req_o[0] === 1'b1) dma_seen++;
  end
  task automatic tick();
    @(posedge sys_clk_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= ad;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, output logic [31:0] d);
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= ad;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] ad, input logic [31:0] exp);
    rd(ad, a);
    chk(a, exp);
  endtask
  // cycles between two update pulses in the given counting setup
  task automatic period(input logic [31:0] ctrl, input int exp);
    int k;
    wr(ACT_OFF_CTRL, ctrl);
    for (int j = 0; j < 2; j++) begin
      k = 0;
      do begin
        tick();
        k++;
      end while (trig_o !== 1'b1 && k < 500);
    end
    chk(k, exp);
    wr(ACT_OFF_CTRL, 32'h0);
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #100000;
    num_errors++;
    complete_run();
  end
  initial begin
    repeat (5) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    rchk(ACT_OFF_ARR, 32'hFFFF);
    rchk(ACT_OFF_PSC, 32'h0);
    rchk(8'h38, 32'h0);
    wr(ACT_OFF_ARR, 32'h2);
    wr(ACT_OFF_PSC, 32'h4);
    wr(ACT_OFF_DMAEN, 32'h1);
    for (int i = 0; i < 4; i++) begin
      if (i == 3) begin
        wr(ACT_OFF_PSC, 32'h0);
        // the prescaler may stand above the new PSC; a CNT write restarts it
        wr(ACT_OFF_CNT, 32'h0);
      end
      period(modes[i], pers[i]);
    end
    chk(dma_seen > 0, 1);
    chk(irq_o, 1'b0);
    wr(ACT_OFF_STAT, 32'h0);
    rchk(ACT_OFF_STAT, 32'h1);
    wr(ACT_OFF_IRQEN, 32'h1);
    tick();
    chk(irq_o, 1'b1);
    wr(ACT_OFF_CLR, 32'h1);
    tick();
    chk(irq_o, 1'b0);
    rchk(ACT_OFF_STAT, 32'h0);
    rchk(ACT_OFF_CLR, 32'h0);
    wr(ACT_OFF_IRQEN, 32'h0);
    wr(ACT_OFF_ARR, 32'h9);
    wr(ACT_OFF_DT, 32'h3);
    wr(ACT_OFF_CHMODE, 32'h0082);
    wr(ACT_OFF_CCR0, 32'h5);
    wr(ACT_OFF_CTRL, 32'h21);
    for (int i = 0; i < 3; i++) begin
      wr(8'h24, duty[i]);
      repeat (5) tick();
      n = 0;
      m = 0;
      repeat (20) begin
        tick();
        if (ch_o[3] === 1'b1) n++;
        if (ch_o[0] === 1'b1 && chn_o[0] === 1'b1) m++;
      end
      chk(n, duty[i] * 2);
      chk(m, 0);
    end
    wr(8'h24, 32'h4);
    for (int i = 0; i < 2; i++) begin
      // toggle compare flips once a period; forced low holds the line down
      wr(ACT_OFF_CHMODE, (i == 0) ? 32'h0040 : 32'h00C0);
      repeat (5) tick();
      n = 0;
      repeat (20) begin
        tick();
        if (ch_o[3] === 1'b1) n++;
      end
      chk(n, (i == 0) ? 10 : 0);
    end
    chk(shoot, 0);
    wr(ACT_OFF_ARR, 32'hFFFF);
    wr(ACT_OFF_CHMODE, 32'h0);
    wr(ACT_OFF_CTRL, 32'h1);
    @(posedge sys_clk_i);
    go <= 1'b1;
    @(posedge sys_clk_i);
    go <= 1'b0;
    repeat (10) tick();
    rd(8'h1C, a);
    wr(ACT_OFF_CHMODE, 32'h0200);
    repeat (40) tick();
    rd(8'h1C, b);
    chk(b - a, 32'd40);
    wr(ACT_OFF_CTRL, 32'h11);
    @(posedge sys_clk_i);
    dbg_halt_i <= 1'b1;
    rd(ACT_OFF_CNT, a);
    repeat (5) tick();
    rchk(ACT_OFF_CNT, a);
    @(posedge sys_clk_i);
    dbg_halt_i <= 1'b0;
    repeat (5) tick();
    rd(ACT_OFF_CNT, b);
    chk(b != a, 1);
    wr(ACT_OFF_CTRL, 32'h81);
    wr(ACT_OFF_CNT, 32'h7);
    repeat (5) tick();
    rchk(ACT_OFF_CNT, 32'h7);
    wr(ACT_OFF_CTRL, 32'hC0);
    @(posedge sys_clk_i);
    trig_i <= 1'b1;
    @(posedge sys_clk_i);
    trig_i <= 1'b0;
    rchk(ACT_OFF_CNT, 32'h0);
    wr(ACT_OFF_CTRL, 32'h40);
    wr(ACT_OFF_CNT, 32'h0);
    rchk(ACT_OFF_CNT, 32'h0);
    @(posedge sys_clk_i);
    trig_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    trig_i <= 1'b0;
    rd(ACT_OFF_CTRL, a);
    chk(a[0], 1'b1);
    wr(ACT_OFF_ARR, 32'h5);
    wr(ACT_OFF_CNT, 32'h0);
    wr(ACT_OFF_CTRL, 32'h9);
    repeat (20) tick();
    rd(ACT_OFF_CTRL, a);
    chk(a[0], 1'b0);
    @(posedge sys_clk_i);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    rchk(ACT_OFF_ARR, 32'hFFFF);
    rchk(ACT_OFF_CTRL, 32'h100);
    complete_run();
  end
endmodule
